// ==== hw/mdc_pin_result.sv ====
// one pin's burst result register pair: outcome flags, pullup code, adc value
`timescale 1ns/1ns
`default_nettype none
module mdc_pin_result (
  input  wire logic      sys_clk,
  input  wire logic      rst,
  input  wire logic      ce,
  mdc_result_if.dst      res,
  output logic [7:0]     outcome_reg,
  output logic [7:0]     adc_reg
);

  // ==========================================================================
  // forced field values
  logic [7:0] outcome_next;
  logic [7:0] adc_next;

  always_comb begin
    outcome_next = mdc_pkg::RESULT_RESET;
    adc_next     = res.adc_value;
    unique case (res.outcome)
      mdc_pkg::MDC_OUT_GROUND: begin
        outcome_next[mdc_pkg::GROUND_FLAG_BIT] = 1'b1;
        outcome_next[mdc_pkg::PULLUP_CODE_LSB +: 2] = mdc_pkg::PULLUP_128UA;
        adc_next = mdc_pkg::ADC_FORCED_LOW;
      end
      mdc_pkg::MDC_OUT_ABORT: begin
        outcome_next[mdc_pkg::ABORT_FLAG_BIT] = 1'b1;
        outcome_next[mdc_pkg::PULLUP_CODE_LSB +: 2] = mdc_pkg::PULLUP_2UA;
        adc_next = mdc_pkg::ADC_FORCED_LOW;
      end
      mdc_pkg::MDC_OUT_OPEN: begin
        outcome_next[mdc_pkg::OPEN_FLAG_BIT] = 1'b1;
        outcome_next[mdc_pkg::PULLUP_CODE_LSB +: 2] = mdc_pkg::PULLUP_2UA;
        adc_next = mdc_pkg::ADC_FORCED_HIGH;
      end
      mdc_pkg::MDC_OUT_VALUE: begin
        outcome_next[mdc_pkg::PULLUP_CODE_LSB +: 2] = res.pullup_code;
      end
    endcase
  end

  // ==========================================================================
  // fields update together
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      outcome_reg <= mdc_pkg::RESULT_RESET;
      adc_reg     <= mdc_pkg::RESULT_RESET;
    end else if (ce && res.update) begin
      outcome_reg <= outcome_next;
      adc_reg     <= adc_next;
    end
  end

endmodule : mdc_pin_result
`default_nettype wire

// ==== hw/mdc_pkg.sv ====
// shared constants for the moisture detection config and result register bank
`default_nettype none
package mdc_pkg;

  // ==========================================================================
  // register map (byte addresses on the serial host register port)
  localparam logic [7:0] ADDR_PULLUP_SELECT   = 8'h52;
  localparam logic [7:0] ADDR_PULLDOWN_SELECT = 8'h53;
  localparam logic [7:0] ADDR_CC1_OUTCOME     = 8'h54;
  localparam logic [7:0] ADDR_CC1_ADC         = 8'h55;
  localparam logic [7:0] ADDR_CC2_OUTCOME     = 8'h56;
  localparam logic [7:0] ADDR_CC2_ADC         = 8'h57;
  localparam logic [7:0] ADDR_SBU1_OUTCOME    = 8'h58;
  localparam logic [7:0] ADDR_SBU1_ADC        = 8'h59;
  localparam logic [7:0] RESULT_PAIR_STRIDE   = 8'h02;

  // ==========================================================================
  // reset values and field widths
  localparam logic [7:0] PULLDOWN_RESET  = 8'h00;
  localparam logic [7:0] PULLUP_RESET    = 8'h00;
  localparam logic [7:0] RESULT_RESET    = 8'h00;
  localparam int         PULLDOWN_WIDTH  = 7;
  localparam int         PULLUP_WIDTH    = 6;
  localparam int         ADC_WIDTH       = 8;
  localparam int         NUM_RESULT_PINS = 3;

  // ==========================================================================
  // outcome register field positions
  localparam int GROUND_FLAG_BIT = 4;
  localparam int ABORT_FLAG_BIT  = 3;
  localparam int OPEN_FLAG_BIT   = 2;
  localparam int PULLUP_CODE_LSB = 0;

  // pulldown select bit positions
  localparam int PD_CC1  = 0;
  localparam int PD_CC2  = 1;
  localparam int PD_SBU1 = 2;
  localparam int PD_SBU2 = 3;
  localparam int PD_CDP  = 4;
  localparam int PD_CDN  = 5;
  localparam int PD_VBUS = 6;

  // pullup select bit positions
  localparam int PU_CC1  = 0;
  localparam int PU_CC2  = 1;
  localparam int PU_SBU2 = 3;
  localparam int PU_CDP  = 4;
  localparam int PU_CDN  = 5;

  // ==========================================================================
  // final pullup current codes
  localparam logic [1:0] PULLUP_2UA   = 2'h0;
  localparam logic [1:0] PULLUP_8UA   = 2'h1;
  localparam logic [1:0] PULLUP_32UA  = 2'h2;
  localparam logic [1:0] PULLUP_128UA = 2'h3;

  // forced adc values
  localparam logic [7:0] ADC_FORCED_LOW  = 8'h00;
  localparam logic [7:0] ADC_FORCED_HIGH = 8'hFF;

  // adc scale in microvolts per count, for software reference only
  localparam int ADC_LSB_UV = 5882;

  // ==========================================================================
  // burst measurement outcome
  typedef enum logic [1:0] {
    MDC_OUT_VALUE  = 2'h0,
    MDC_OUT_GROUND = 2'h1,
    MDC_OUT_ABORT  = 2'h2,
    MDC_OUT_OPEN   = 2'h3
  } mdc_outcome_e;

  // pins that own a result pair
  localparam logic [1:0] PIN_CC1  = 2'h0;
  localparam logic [1:0] PIN_CC2  = 2'h1;
  localparam logic [1:0] PIN_SBU1 = 2'h2;

endpackage : mdc_pkg
`default_nettype wire

// ==== hw/mdc_result_if.sv ====
// carrier for one burst result from the bank decoder to a per-pin result pair
`timescale 1ns/1ns
`default_nettype none
interface mdc_result_if;
  logic                        update;
  mdc_pkg::mdc_outcome_e       outcome;
  logic [1:0]                  pullup_code;
  logic [mdc_pkg::ADC_WIDTH-1:0] adc_value;

  modport src (output update, output outcome, output pullup_code, output adc_value);
  modport dst (input update, input outcome, input pullup_code, input adc_value);
endinterface : mdc_result_if
`default_nettype wire

// ==== hw/mdc_top.sv ====
// moisture detection manual switch selection and burst result register bank
// ============================================================================
// Contract
// - seven pulldown select bits close CC1..CDN and bus supply pulldowns.
// - manual selections act only while auto configuration is off.
// - pullup select bit 4 drives CDP, bit 5 drives CDN switches.
// - pullup select bit 0 CC1, bit 1 CC2, bit 3 SBU2.
// - auto configuration uses the engine's own pin selection, not manual.
// - ground flag, bit 4, set only when latest burst ended Ground.
// - abort flag, bit 3, set only when latest burst was aborted.
// - open flag, bit 2, set only when latest burst ended Open.
// - two-bit final pullup code: 2, 8, 32, 128 uA.
// - code forced 00 on Abort or Open, 11 on Ground.
// - adc value forced 00 on Abort/Ground, FF on Open.
// - adc count is 5.882 mV, passed through unscaled.
// - CC1, CC2, SBU1 result pairs read-only, consecutive, reset zero.
`timescale 1ns/1ns
`default_nettype none
module mdc_top #(
  parameter int NUM_PINS = mdc_pkg::NUM_RESULT_PINS,
  parameter int ADC_BITS = mdc_pkg::ADC_WIDTH
) (
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  input  wire logic                              ce,
  // register port from the serial host interface engine
  input  wire logic                              reg_wr_en,
  input  wire logic                              reg_rd_en,
  input  wire logic [7:0]                        reg_addr,
  input  wire logic [7:0]                        reg_wdata,
  output logic [7:0]                             reg_rdata,
  output logic                                   reg_rdata_valid,
  // from the rest of the unit
  input  wire logic                              auto_config_enable,
  input  wire logic [mdc_pkg::PULLDOWN_WIDTH-1:0] auto_pulldown_en,
  input  wire logic [mdc_pkg::PULLUP_WIDTH-1:0]   auto_pullup_en,
  // measurement engine result
  input  wire logic                              burst_done,
  input  wire logic [1:0]                        burst_pin,
  input  wire logic [1:0]                        burst_outcome,
  input  wire logic [1:0]                        burst_pullup_code,
  input  wire logic [ADC_BITS-1:0]               burst_adc_value,
  // switch controls
  output logic [mdc_pkg::PULLDOWN_WIDTH-1:0]     pulldown_switch_en,
  output logic [mdc_pkg::PULLUP_WIDTH-1:0]       pullup_switch_en,
  output logic [mdc_pkg::PULLUP_WIDTH-1:0]       manual_pullup_select
);

  // ==========================================================================
  // elaboration checks
  if (NUM_PINS != mdc_pkg::NUM_RESULT_PINS) begin : g_bad_pins
    $error("mdc_top: NUM_PINS must equal the number of result pairs");
  end
  if (ADC_BITS != mdc_pkg::ADC_WIDTH) begin : g_bad_adc
    $error("mdc_top: ADC_BITS must be 8, the result register width");
  end

  // ==========================================================================
  // manual selection registers
  logic [mdc_pkg::PULLDOWN_WIDTH-1:0] manual_pulldown_select_reg;
  logic [mdc_pkg::PULLUP_WIDTH-1:0]   manual_pullup_select_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      manual_pulldown_select_reg <= mdc_pkg::PULLDOWN_RESET[mdc_pkg::PULLDOWN_WIDTH-1:0];
    end else if (ce && reg_wr_en && reg_addr == mdc_pkg::ADDR_PULLDOWN_SELECT) begin
      manual_pulldown_select_reg <= reg_wdata[mdc_pkg::PULLDOWN_WIDTH-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      manual_pullup_select_reg <= mdc_pkg::PULLUP_RESET[mdc_pkg::PULLUP_WIDTH-1:0];
    end else if (ce && reg_wr_en && reg_addr == mdc_pkg::ADDR_PULLUP_SELECT) begin
      manual_pullup_select_reg <= reg_wdata[mdc_pkg::PULLUP_WIDTH-1:0];
    end
  end

  assign manual_pullup_select = manual_pullup_select_reg;

  // ==========================================================================
  // switch control outputs
  logic [mdc_pkg::PULLDOWN_WIDTH-1:0] pulldown_switch_next;
  logic [mdc_pkg::PULLUP_WIDTH-1:0]   pullup_switch_next;

  always_comb begin
    pulldown_switch_next = '0;
    pullup_switch_next   = '0;
    if (auto_config_enable) begin
      pulldown_switch_next = auto_pulldown_en;
      pullup_switch_next   = auto_pullup_en;
    end else begin
      pulldown_switch_next = manual_pulldown_select_reg;
      pullup_switch_next[mdc_pkg::PU_CC1]  = manual_pullup_select_reg[mdc_pkg::PU_CC1];
      pullup_switch_next[mdc_pkg::PU_CC2]  = manual_pullup_select_reg[mdc_pkg::PU_CC2];
      pullup_switch_next[mdc_pkg::PU_SBU2] = manual_pullup_select_reg[mdc_pkg::PU_SBU2];
      pullup_switch_next[mdc_pkg::PU_CDP]  = manual_pullup_select_reg[mdc_pkg::PU_CDP];
      pullup_switch_next[mdc_pkg::PU_CDN]  = manual_pullup_select_reg[mdc_pkg::PU_CDN];
      // bit 2 has no documented pin, kept for the engine that owns it
      pullup_switch_next[2]                = manual_pullup_select_reg[2];
    end
  end

  // registered so switch drivers never see a decode glitch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulldown_switch_en <= '0;
      pullup_switch_en   <= '0;
    end else if (ce) begin
      pulldown_switch_en <= pulldown_switch_next;
      pullup_switch_en   <= pullup_switch_next;
    end
  end

  // ==========================================================================
  // per-pin result pairs
  mdc_result_if res_if [NUM_PINS] ();
  logic [7:0] outcome_regs [NUM_PINS];
  logic [7:0] adc_regs     [NUM_PINS];

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    assign res_if[p].update      = burst_done && (burst_pin == 2'(p));
    assign res_if[p].outcome     = mdc_pkg::mdc_outcome_e'(burst_outcome);
    assign res_if[p].pullup_code = burst_pullup_code;
    assign res_if[p].adc_value   = burst_adc_value;

    mdc_pin_result u_pin_result (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .ce          (ce),
      .res         (res_if[p]),
      .outcome_reg (outcome_regs[p]),
      .adc_reg     (adc_regs[p])
    );
  end

  // ==========================================================================
  // register read path
  logic [7:0] rdata_next;
  logic [7:0] result_offset;

  always_comb begin
    rdata_next    = 8'h00;
    result_offset = reg_addr - mdc_pkg::ADDR_CC1_OUTCOME;
    if (reg_addr == mdc_pkg::ADDR_PULLDOWN_SELECT) begin
      rdata_next = {1'b0, manual_pulldown_select_reg};
    end else if (reg_addr == mdc_pkg::ADDR_PULLUP_SELECT) begin
      rdata_next = {2'b00, manual_pullup_select_reg};
    end else begin
      for (int p = 0; p < NUM_PINS; p++) begin
        if (result_offset == 8'(p) * mdc_pkg::RESULT_PAIR_STRIDE)
          rdata_next = outcome_regs[p];
        if (result_offset == 8'(p) * mdc_pkg::RESULT_PAIR_STRIDE + 8'h01)
          rdata_next = adc_regs[p];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata       <= 8'h00;
      reg_rdata_valid <= 1'b0;
    end else if (ce) begin
      reg_rdata_valid <= reg_rd_en;
      if (reg_rd_en)
        reg_rdata <= rdata_next;
    end
  end

endmodule : mdc_top
`default_nettype wire

// ==== tb/mdc_top_asserts.sv ====
// concurrent checks on the moisture result bank ports
`timescale 1ns/1ns
`default_nettype none
module mdc_asserts (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rdata_valid,
  input wire logic       auto_config_enable,
  input wire logic [6:0] auto_pulldown_en,
  input wire logic [5:0] auto_pullup_en,
  input wire logic       burst_done,
  input wire logic [1:0] burst_pin,
  input wire logic [1:0] burst_outcome,
  input wire logic [6:0] pulldown_switch_en,
  input wire logic [5:0] pullup_switch_en,
  input wire logic [5:0] manual_pullup_select
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // burst on cc1 then a read in the very next cycle
  sequence s_b0(oc, a);
    ce && burst_done && burst_pin == 2'h0 && burst_outcome == oc ##1 ce && !burst_done && reg_rd_en && reg_addr == a;
  endsequence
  property p_rd_valid; ce && reg_rd_en |=> reg_rdata_valid; endproperty
  property p_valid_pulse; ce && !reg_rd_en |=> !reg_rdata_valid; endproperty
  property p_unmapped; ce && reg_rd_en && reg_addr > 8'h59 |=> reg_rdata == 8'h00; endproperty
  property p_auto_pd; ce && auto_config_enable |=> pulldown_switch_en == $past(auto_pulldown_en); endproperty
  property p_auto_pu; ce && auto_config_enable |=> pullup_switch_en == $past(auto_pullup_en); endproperty
  property p_man_pu; ce && !auto_config_enable |=> pullup_switch_en == $past(manual_pullup_select); endproperty
  property p_gnd; s_b0(2'h1, 8'h54) |=> reg_rdata == 8'h13; endproperty
  property p_abort; s_b0(2'h2, 8'h54) |=> reg_rdata == 8'h08; endproperty
  property p_open; s_b0(2'h3, 8'h55) |=> reg_rdata == 8'hFF; endproperty
  property p_one_flag; ce && reg_rd_en && reg_addr inside {8'h54, 8'h56, 8'h58}
    |=> $countones(reg_rdata[4:2]) <= 1 && reg_rdata[7:5] == 3'h0; endproperty
  // ==========================================================================
  // assertions
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered next cycle");
  a_valid_pulse: assert property (p_valid_pulse) else $error("read valid without read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_auto_pd: assert property (p_auto_pd) else $error("auto pulldown not followed");
  a_auto_pu: assert property (p_auto_pu) else $error("auto pullup not followed");
  a_man_pu: assert property (p_man_pu) else $error("manual pullup not applied");
  a_gnd: assert property (p_gnd) else $error("ground outcome wrong");
  a_abort: assert property (p_abort) else $error("abort outcome wrong");
  a_open: assert property (p_open) else $error("open adc not forced high");
  a_one_flag: assert property (p_one_flag) else $error("more than one outcome flag set");
  c_burst: cover property (ce && burst_done && burst_pin != 2'h3);
  c_read: cover property (reg_rdata_valid);
  c_auto: cover property (ce && $rose(auto_config_enable));
endmodule : mdc_asserts
bind mdc_top mdc_asserts u_chk (.sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
  .auto_config_enable(auto_config_enable), .auto_pulldown_en(auto_pulldown_en), .auto_pullup_en(auto_pullup_en),
  .burst_done(burst_done), .burst_pin(burst_pin), .burst_outcome(burst_outcome),
  .pulldown_switch_en(pulldown_switch_en), .pullup_switch_en(pullup_switch_en),
  .manual_pullup_select(manual_pullup_select));
`default_nettype wire

// ==== tb/test_moisture_detect_cfg_results.sv ====
// self-checking bench for the moisture result register bank
`timescale 1ns/1ns
`default_nettype none
module test_moisture_detect_cfg_results;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  logic       reg_wr_en = 1'b0;
  logic       reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic       reg_rdata_valid;
  logic       auto_config_enable = 1'b0;
  logic [6:0] auto_pulldown_en = 7'h00;
  logic [5:0] auto_pullup_en = 6'h00;
  logic       burst_done = 1'b0;
  logic [1:0] burst_pin = 2'h0;
  logic [1:0] burst_outcome = 2'h0;
  logic [1:0] burst_pullup_code = 2'h0;
  logic [7:0] burst_adc_value = 8'h00;
  logic [6:0] pulldown_switch_en;
  logic [5:0] pullup_switch_en;
  logic [5:0] manual_pullup_select;
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         seed = 52;
  int         i;
  int         pu_m = 0;
  int         pd_m = 0;
  int         out_m [3] = '{0, 0, 0};
  int         adc_m [3] = '{0, 0, 0};

  always #4 sys_clk = ~sys_clk;

  mdc_top u_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .auto_config_enable(auto_config_enable), .auto_pulldown_en(auto_pulldown_en), .auto_pullup_en(auto_pullup_en),
    .burst_done(burst_done), .burst_pin(burst_pin), .burst_outcome(burst_outcome),
    .burst_pullup_code(burst_pullup_code), .burst_adc_value(burst_adc_value),
    .pulldown_switch_en(pulldown_switch_en), .pullup_switch_en(pullup_switch_en),
    .manual_pullup_select(manual_pullup_select));

  // ==========================================================================
  // model and bus tasks
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  function automatic int exp_rd(input int a);
    if (a == 8'h52) return pu_m;
    if (a == 8'h53) return pd_m;
    if (a >= 8'h54 && a <= 8'h59) return (a % 2 == 0) ? out_m[(a - 8'h54) / 2] : adc_m[(a - 8'h54) / 2];
    return 0;
  endfunction : exp_rd

  // burst_done is dropped by the next bus task so a read can follow at once
  task automatic burst(input int p, input int oc, input int code, input int adc);
    @(posedge sys_clk);
    burst_done <= 1'b1;
    burst_pin <= 2'(p);
    burst_outcome <= 2'(oc);
    burst_pullup_code <= 2'(code);
    burst_adc_value <= 8'(adc);
    if (p < 3) begin
      out_m[p] = (oc == 1) ? 8'h13 : (oc == 2) ? 8'h08 : (oc == 3) ? 8'h04 : code;
      adc_m[p] = (oc == 0) ? adc : (oc == 3) ? 8'hFF : 8'h00;
    end
  endtask : burst

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    burst_done <= 1'b0;
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    @(negedge sys_clk);
    chk("rdata_valid", 8'h01, {7'h00, reg_rdata_valid});
    chk("rdata", 8'(exp_rd(a)), reg_rdata);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    burst_done <= 1'b0;
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    if (ce === 1'b1 && a == 8'h52) pu_m = d & 8'h3F;
    if (ce === 1'b1 && a == 8'h53) pd_m = d & 8'h7F;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
  endtask : wr

  task automatic sw_chk;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("pulldown_sw", auto_config_enable ? {1'b0, auto_pulldown_en} : 8'(pd_m), {1'b0, pulldown_switch_en});
    chk("pullup_sw", auto_config_enable ? {2'b00, auto_pullup_en} : 8'(pu_m), {2'b00, pullup_switch_en});
    chk("manual_pullup", 8'(pu_m), {2'b00, manual_pullup_select});
  endtask : sw_chk

  task automatic rd_all;
    for (int a = 8'h50; a <= 8'h5B; a++) rd(8'(a));
    rd(8'hFF);
  endtask : rd_all

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // scenarios
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd_all;
    for (i = 0; i < 4; i++) begin
      burst(0, i, 2, 8'h40);
      rd(8'h54);
      burst(0, i, 1, 8'h3C);
      rd(8'h55);
    end
    for (i = 0; i < 40; i++) begin
      burst($random(seed) & 3, $random(seed) & 3, $random(seed) & 3, $random(seed) & 255);
      rd(8'(8'h54 + 2 * (i % 3)));
      rd(8'(8'h55 + 2 * (i % 3)));
      wr(8'(8'h54 + (i % 6)), 8'($random(seed)));
      wr(8'(8'h52 + (i % 2)), 8'($random(seed)));
      auto_config_enable <= i[0];
      auto_pulldown_en <= 7'($random(seed));
      auto_pullup_en <= 6'($random(seed));
      sw_chk;
      rd(8'(8'h52 + (i % 2)));
    end
    // a write while the clock enable is low must leave the select alone
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(8'h53, 8'h2A);
    ce <= 1'b1;
    rd(8'h53);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    pu_m = 0;
    pd_m = 0;
    out_m = '{0, 0, 0};
    adc_m = '{0, 0, 0};
    rd_all;
    print_verdict;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict;
  end
endmodule : test_moisture_detect_cfg_results
`default_nettype wire
